// file: design/msbfe_core.sv
// Our own choices: the AHB-Lite slave port and the register addresses.
`include "msbfe_params.svh"

// Behaviour
// - Direct load copies byte, two cycles
// - Post-increment store writes, then bumps pointer
// - Pre-decrement store decrements pointer, then writes
// - Displacement store, Y/Z only, pointer kept
// - Direct store writes absolute address, two cycles
// - Code read via Z, three cycles, optional increment
// - Code write stores R1:R0 at Z
// - Push writes register to stack, two cycles
// - Pop loads register from stack, two cycles
// - I/O bit set/clear in two cycles
// - Rotate left through carry, flags, one cycle
// - Rotate right through carry, flags, one cycle
// - Arithmetic right shift keeps bit 7
// - Bit capture copies register bit into T
// - Bit load copies T into register bit
// - Interrupt enable flag set or cleared
// - Overflow flag set or cleared
// - Half-carry flag set or cleared
// - Signed-test flag set or cleared
// - Break only signals the debug function
module msbfe_core #(
  parameter int         DMEM_AW    = 8,
  parameter int         CODE_AW    = 8,
  parameter logic [7:0] SPM_CYCLES = 8'h04
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             sleepReq,
  output logic             watchdogRestart,
  output logic             debugBreak
);
  import msbfe_pkg::*;

  logic                  rstMeta;
  logic                  rstSync;
  logic                  dPhase;
  logic                  dWrite;
  logic [7:0]            dAddr;
  logic                  accept;
  logic                  busWr;
  logic                  busy;
  logic [31:0]           readMux;
  logic [`MSBFE_CMD_W-1:0] cmd;
  logic [15:0]           addrK;
  logic [7:0]            statusFlags;
  logic [15:0]           sp;
  logic [4:0]            regIdx;
  logic [15:0]           memAddr;
  logic [7:0]            regFile [32];
  logic [7:0]            dMem    [2**DMEM_AW];
  logic [7:0]            ioMem   [64];
  logic [15:0]           codeMem [2**CODE_AW];
  msbfe_state_t          execState;
  logic [7:0]            cnt;
  logic                  doneNow;
  msbfe_op_t             op;
  msbfe_ptr_mode_t       mode;
  logic [4:0]            regSel;
  logic [2:0]            bitSel;
  logic [1:0]            ptrSel;
  logic [5:0]            imm;
  logic [7:0]            srcVal;
  logic [15:0]           curPtr;
  logic [15:0]           zPtr;
  logic                  wrRd;
  logic [4:0]            rdDest;
  logic [7:0]            rdVal;
  logic                  wrPtr;
  logic [1:0]            ptrWrSel;
  logic [15:0]           ptrNew;
  logic                  wrMem;
  logic [15:0]           memA;
  logic                  wrIo;
  logic [7:0]            ioVal;
  logic                  wrCode;
  logic [7:0]            next_flags;
  logic [15:0]           next_sp;
  logic [7:0]            shiftRes;
  logic                  shiftC;

  function automatic logic [4:0] pairLo(input logic [1:0] sel);
    pairLo = 5'h1A + {2'h0, sel, 1'b0};
  endfunction

  function automatic logic [15:0] pairVal(input logic [1:0] sel);
    logic [4:0] lo;
    lo = pairLo(sel);
    pairVal = {regFile[lo + 5'h01], regFile[lo]};
  endfunction

  function automatic logic [7:0] cycFor(input msbfe_op_t o);
    case (o)
      OP_DIRECT_DATA_LOAD, OP_DIRECT_DATA_WRITE: cycFor = `MSBFE_CYC_DIRECT;
      OP_POINTER_WRITE:                      cycFor = `MSBFE_CYC_POINTER;
      OP_PUSH, OP_POP:                       cycFor = `MSBFE_CYC_STACK;
      OP_IO_BIT_SET, OP_IO_BIT_CLEAR:        cycFor = `MSBFE_CYC_IO_BIT;
      OP_CODE_MEMORY_READ:                   cycFor = `MSBFE_CYC_CODE_READ;
      OP_CODE_MEMORY_WRITE:                  cycFor = SPM_CYCLES;
      default:                               cycFor = `MSBFE_CYC_SINGLE;
    endcase
  endfunction

  function automatic logic [7:0] shiftFlags(input logic [7:0] f,
                                            input logic [7:0] r,
                                            input logic       c);
    logic [7:0] n;
    n = f;
    n[`MSBFE_FLAG_C] = c;
    n[`MSBFE_FLAG_Z] = (r == 8'h00);
    n[`MSBFE_FLAG_N] = r[7];
    n[`MSBFE_FLAG_V] = r[7] ^ c;
    shiftFlags = n;
  endfunction

  // Reset release through two flops
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // Bus slave, one wait state, writes stall while busy
  assign accept = hsel && htrans[1] && hready;
  assign busWr  = dPhase && dWrite && !busy;
  assign busy   = (execState == EX_RUN);

  always_ff @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      dPhase    <= 1'b0;
      dWrite    <= 1'b0;
      dAddr     <= 8'h00;
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      hresp     <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (accept) begin
        dPhase    <= 1'b1;
        dWrite    <= hwrite;
        dAddr     <= haddr[7:0];
        hreadyout <= 1'b0;
      end else if (dPhase && !(dWrite && busy)) begin
        dPhase    <= 1'b0;
        hreadyout <= 1'b1;
        if (!dWrite) begin
          hrdata <= readMux;
        end
      end
    end
  end

  always_comb begin
    readMux = 32'h0000_0000;
    case (dAddr)
      `MSBFE_OFF_CMD:      readMux = {9'h000, cmd};
      `MSBFE_OFF_ADDR:     readMux = {16'h0000, addrK};
      `MSBFE_OFF_STATUS:   readMux = {31'h0000_0000, busy};
      `MSBFE_OFF_FLAGS:    readMux = {24'h00_0000, statusFlags};
      `MSBFE_OFF_SP:       readMux = {16'h0000, sp};
      `MSBFE_OFF_REGIDX:   readMux = {27'h000_0000, regIdx};
      `MSBFE_OFF_REGDATA:  readMux = {24'h00_0000, regFile[regIdx]};
      `MSBFE_OFF_MEMADDR:  readMux = {16'h0000, memAddr};
      `MSBFE_OFF_MEMDATA:
        readMux = {24'h00_0000, dMem[memAddr[DMEM_AW-1:0]]};
      `MSBFE_OFF_IODATA:   readMux = {24'h00_0000, ioMem[memAddr[5:0]]};
      `MSBFE_OFF_CODEDATA:
        readMux = {16'h0000, codeMem[memAddr[CODE_AW-1:0]]};
      default:             readMux = 32'h0000_0000;
    endcase
  end

  // Software-written control registers
  always_ff @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      cmd     <= '0;
      addrK   <= 16'h0000;
      regIdx  <= 5'h00;
      memAddr <= 16'h0000;
    end else if (busWr) begin
      case (dAddr)
        `MSBFE_OFF_CMD:     cmd     <= hwdata[`MSBFE_CMD_W-1:0];
        `MSBFE_OFF_ADDR:    addrK   <= hwdata[15:0];
        `MSBFE_OFF_REGIDX:  regIdx  <= hwdata[4:0];
        `MSBFE_OFF_MEMADDR: memAddr <= hwdata[15:0];
        default:            cmd     <= cmd;
      endcase
    end
  end

  // Sequencer holding each command for its cycle count
  always_ff @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      execState <= EX_IDLE;
      cnt       <= 8'h00;
    end else begin
      case (execState)
        EX_IDLE: begin
          if (busWr && dAddr == `MSBFE_OFF_CMD) begin
            execState <= EX_RUN;
            cnt <= cycFor(msbfe_op_t'(hwdata[`MSBFE_F_OP])) - 8'h01;
          end
        end
        EX_RUN: begin
          if (cnt == 8'h00) begin
            execState <= EX_IDLE;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        default: execState <= EX_IDLE;
      endcase
    end
  end

  assign doneNow = busy && (cnt == 8'h00);
  assign op      = msbfe_op_t'(cmd[`MSBFE_F_OP]);
  assign mode    = msbfe_ptr_mode_t'(cmd[`MSBFE_F_MODE]);
  assign regSel  = cmd[`MSBFE_F_REG];
  assign bitSel  = cmd[`MSBFE_F_BIT];
  assign ptrSel  = (cmd[`MSBFE_F_PTR] == 2'h3) ? 2'h2 : cmd[`MSBFE_F_PTR];
  assign imm     = cmd[`MSBFE_F_IMM];
  assign srcVal  = regFile[regSel];

  // Pointer pairs follow every working register write
  always_comb begin
    curPtr = pairVal(ptrSel);
    zPtr   = pairVal(2'h2);
  end

  // Effects applied in the last cycle of a command
  always_comb begin
    wrRd       = 1'b0;
    rdDest     = regSel;
    rdVal      = srcVal;
    wrPtr      = 1'b0;
    ptrWrSel   = ptrSel;
    ptrNew     = curPtr;
    wrMem      = 1'b0;
    memA       = curPtr;
    wrIo       = 1'b0;
    ioVal      = srcVal;
    wrCode     = 1'b0;
    next_flags = statusFlags;
    next_sp    = sp;
    shiftRes   = srcVal;
    shiftC     = srcVal[0];
    if (doneNow) begin
      case (op)
        OP_DIRECT_DATA_LOAD: begin
          wrRd  = 1'b1;
          rdVal = dMem[addrK[DMEM_AW-1:0]];
        end
        OP_DIRECT_DATA_WRITE: begin
          wrMem = 1'b1;
          memA  = addrK;
        end
        OP_POINTER_WRITE: begin
          case (mode)
            PM_POST_INC: begin
              wrMem  = 1'b1;
              wrPtr  = 1'b1;
              ptrNew = curPtr + 16'h0001;
            end
            PM_PRE_DEC: begin
              wrMem  = 1'b1;
              wrPtr  = 1'b1;
              ptrNew = curPtr - 16'h0001;
              memA   = curPtr - 16'h0001;
            end
            PM_DISP: begin
              wrMem = (ptrSel != 2'h0);
              memA  = curPtr + {10'h000, imm};
            end
            default: wrMem = 1'b1;
          endcase
        end
        OP_CODE_MEMORY_READ: begin
          wrRd     = 1'b1;
          rdDest   = (mode == PM_PLAIN) ? 5'h00 : regSel;
          rdVal    = zPtr[0] ? codeMem[zPtr[CODE_AW:1]][15:8]
                             : codeMem[zPtr[CODE_AW:1]][7:0];
          wrPtr    = (mode == PM_PRE_DEC);
          ptrWrSel = 2'h2;
          ptrNew   = zPtr + 16'h0001;
        end
        OP_CODE_MEMORY_WRITE: wrCode = 1'b1;
        OP_IO_READ: begin
          wrRd  = 1'b1;
          rdVal = ioMem[imm];
        end
        OP_IO_WRITE: wrIo = 1'b1;
        OP_PUSH: begin
          wrMem   = 1'b1;
          memA    = sp;
          next_sp = sp - 16'h0001;
        end
        OP_POP: begin
          wrRd    = 1'b1;
          next_sp = sp + 16'h0001;
          rdVal   = dMem[next_sp[DMEM_AW-1:0]];
        end
        OP_IO_BIT_SET, OP_IO_BIT_CLEAR: begin
          wrIo          = 1'b1;
          ioVal         = ioMem[imm];
          ioVal[bitSel] = (op == OP_IO_BIT_SET);
        end
        OP_LEFT_SHIFT_ZERO, OP_RIGHT_SHIFT_ZERO: begin
          wrRd       = 1'b1;
          shiftRes   = (op == OP_LEFT_SHIFT_ZERO) ? {srcVal[6:0], 1'b0}
                                                  : {1'b0, srcVal[7:1]};
          shiftC     = (op == OP_LEFT_SHIFT_ZERO) ? srcVal[7] : srcVal[0];
          rdVal      = shiftRes;
          next_flags = shiftFlags(statusFlags, shiftRes, shiftC);
        end
        OP_ROTATE_LEFT_CARRY: begin
          wrRd       = 1'b1;
          shiftRes   = {srcVal[6:0], statusFlags[`MSBFE_FLAG_C]};
          shiftC     = srcVal[7];
          rdVal      = shiftRes;
          next_flags = shiftFlags(statusFlags, shiftRes, shiftC);
        end
        OP_ROTATE_RIGHT_CARRY: begin
          wrRd       = 1'b1;
          shiftRes   = {statusFlags[`MSBFE_FLAG_C], srcVal[7:1]};
          rdVal      = shiftRes;
          next_flags = shiftFlags(statusFlags, shiftRes, shiftC);
        end
        OP_ARITH_RIGHT_SHIFT: begin
          wrRd       = 1'b1;
          shiftRes   = {srcVal[7], srcVal[7:1]};
          rdVal      = shiftRes;
          next_flags = shiftFlags(statusFlags, shiftRes, shiftC);
        end
        OP_NIBBLE_SWAP: begin
          wrRd  = 1'b1;
          rdVal = {srcVal[3:0], srcVal[7:4]};
        end
        OP_FLAG_SET:   next_flags[bitSel] = 1'b1;
        OP_FLAG_CLEAR: next_flags[bitSel] = 1'b0;
        OP_T_FLAG_CAPTURE: next_flags[`MSBFE_FLAG_T] = srcVal[bitSel];
        OP_T_FLAG_TO_BIT: begin
          wrRd          = 1'b1;
          rdVal[bitSel] = statusFlags[`MSBFE_FLAG_T];
        end
        default: wrRd = 1'b0;
      endcase
    end
  end

  // Status flags and stack pointer
  always_ff @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      statusFlags <= `MSBFE_FLAGS_RESET;
      sp          <= `MSBFE_SP_RESET;
    end else if (busWr && dAddr == `MSBFE_OFF_FLAGS) begin
      statusFlags <= hwdata[7:0];
    end else if (busWr && dAddr == `MSBFE_OFF_SP) begin
      sp <= hwdata[15:0];
    end else begin
      statusFlags <= next_flags;
      sp          <= next_sp;
    end
  end

  // Working registers, pointer update last
  always_ff @(posedge sys_clk) begin
    if (busWr && dAddr == `MSBFE_OFF_REGDATA) begin
      regFile[regIdx] <= hwdata[7:0];
    end
    if (wrRd) begin
      regFile[rdDest] <= rdVal;
    end
    if (wrPtr) begin
      regFile[pairLo(ptrWrSel)]         <= ptrNew[7:0];
      regFile[pairLo(ptrWrSel) + 5'h01] <= ptrNew[15:8];
    end
  end

  // Data, I/O and code memories
  always_ff @(posedge sys_clk) begin
    if (busWr && dAddr == `MSBFE_OFF_MEMDATA) begin
      dMem[memAddr[DMEM_AW-1:0]] <= hwdata[7:0];
    end
    if (wrMem) begin
      dMem[memA[DMEM_AW-1:0]] <= srcVal;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (busWr && dAddr == `MSBFE_OFF_IODATA) begin
      ioMem[memAddr[5:0]] <= hwdata[7:0];
    end
    if (wrIo) begin
      ioMem[imm] <= ioVal;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (busWr && dAddr == `MSBFE_OFF_CODEDATA) begin
      codeMem[memAddr[CODE_AW-1:0]] <= hwdata[15:0];
    end
    if (wrCode) begin
      codeMem[zPtr[CODE_AW:1]] <= {regFile[1], regFile[0]};
    end
  end

  always_ff @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      sleepReq        <= 1'b0;
      watchdogRestart <= 1'b0;
      debugBreak      <= 1'b0;
    end else begin
      sleepReq        <= doneNow && (op == OP_SLEEP);
      watchdogRestart <= doneNow && (op == OP_WATCHDOG_RESTART);
      debugBreak      <= doneNow && (op == OP_BREAK);
    end
  end

  // Checks
  logic [7:0] runLen;
  logic       srcBit;
  always_ff @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      runLen <= 8'h00;
    end else if (!busy) begin
      runLen <= 8'h01;
    end else begin
      runLen <= runLen + 8'h01;
    end
  end
  assign srcBit = srcVal[bitSel];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstSync);

  a_load_direct_len: assert property (
    doneNow && op == OP_DIRECT_DATA_LOAD |-> runLen == 8'h02
      ##1 statusFlags == $past(statusFlags))
    else $error("direct load length or flags wrong");
  a_post_inc_ptr: assert property (
    doneNow && op == OP_POINTER_WRITE && mode == PM_POST_INC
      |-> memA == curPtr ##1 curPtr == $past(curPtr) + 16'h0001)
    else $error("post-increment store wrong");
  a_pre_dec_ptr: assert property (
    doneNow && op == OP_POINTER_WRITE && mode == PM_PRE_DEC
      |-> memA == curPtr - 16'h0001 ##1 curPtr == $past(memA))
    else $error("pre-decrement store wrong");
  a_disp_keeps_ptr: assert property (
    doneNow && op == OP_POINTER_WRITE && mode == PM_DISP
      |-> runLen == 8'h02 ##1 $stable(curPtr))
    else $error("displacement store moved pointer");
  a_direct_store: assert property (
    doneNow && op == OP_DIRECT_DATA_WRITE
      |-> wrMem && memA == addrK && runLen == 8'h02)
    else $error("direct store wrong");
  a_code_read_len: assert property (
    $rose(busy) && op == OP_CODE_MEMORY_READ |-> busy [*3] ##1 !busy)
    else $error("code read not three cycles");
  a_push_sp: assert property (
    doneNow && op == OP_PUSH |-> runLen == 8'h02
      ##1 sp == $past(sp) - 16'h0001)
    else $error("push wrong");
  a_pop_sp: assert property (
    doneNow && op == OP_POP |=> sp == $past(sp) + 16'h0001)
    else $error("pop stack pointer wrong");
  a_io_bit_set: assert property (
    doneNow && op == OP_IO_BIT_SET |=> ioMem[imm][bitSel] == 1'b1)
    else $error("I/O bit not set");
  a_rotate_carry: assert property (
    doneNow && op == OP_ROTATE_LEFT_CARRY |-> runLen == 8'h01
      ##1 statusFlags[`MSBFE_FLAG_C] == $past(shiftC))
    else $error("rotate carry wrong");
  a_t_capture: assert property (
    doneNow && op == OP_T_FLAG_CAPTURE
      |=> statusFlags[`MSBFE_FLAG_T] == $past(srcBit))
    else $error("T capture wrong");
  a_single_cycle: assert property (
    doneNow && (op == OP_NOP || op == OP_SLEEP) |-> runLen == 8'h01
      ##1 statusFlags == $past(statusFlags))
    else $error("control op not single cycle");

  c_pre_dec: cover property (doneNow && op == OP_POINTER_WRITE
                             && mode == PM_PRE_DEC);
  c_code_read: cover property (doneNow && op == OP_CODE_MEMORY_READ);
  c_push_pop: cover property (doneNow && op == OP_PUSH ##[1:20]
                              doneNow && op == OP_POP);
  c_write_stall: cover property (dPhase && dWrite && busy);
endmodule

// file: design/msbfe_params.svh
`ifndef MSBFE_PARAMS_SVH
`define MSBFE_PARAMS_SVH

// Register byte offsets
`define MSBFE_OFF_CMD      8'h00
`define MSBFE_OFF_ADDR     8'h04
`define MSBFE_OFF_STATUS   8'h08
`define MSBFE_OFF_FLAGS    8'h0C
`define MSBFE_OFF_SP       8'h10
`define MSBFE_OFF_REGIDX   8'h14
`define MSBFE_OFF_REGDATA  8'h18
`define MSBFE_OFF_MEMADDR  8'h1C
`define MSBFE_OFF_MEMDATA  8'h20
`define MSBFE_OFF_IODATA   8'h24
`define MSBFE_OFF_CODEDATA 8'h28

// Command word fields
`define MSBFE_F_OP   4:0
`define MSBFE_F_REG  9:5
`define MSBFE_F_BIT  12:10
`define MSBFE_F_PTR  14:13
`define MSBFE_F_MODE 16:15
`define MSBFE_F_IMM  22:17
`define MSBFE_CMD_W  23

// Status flag positions
`define MSBFE_FLAG_C 0
`define MSBFE_FLAG_Z 1
`define MSBFE_FLAG_N 2
`define MSBFE_FLAG_V 3
`define MSBFE_FLAG_S 4
`define MSBFE_FLAG_H 5
`define MSBFE_FLAG_T 6
`define MSBFE_FLAG_I 7

// Reset values
`define MSBFE_FLAGS_RESET 8'h00
`define MSBFE_SP_RESET    16'h00FF

// Execution lengths in clock cycles
`define MSBFE_CYC_DIRECT    8'h02
`define MSBFE_CYC_POINTER   8'h02
`define MSBFE_CYC_STACK     8'h02
`define MSBFE_CYC_IO_BIT    8'h02
`define MSBFE_CYC_CODE_READ 8'h03
`define MSBFE_CYC_SINGLE    8'h01

`endif

// file: design/msbfe_pkg.sv
package msbfe_pkg;
  typedef enum logic [4:0] {
    OP_NOP                 = 5'h00,
    OP_SLEEP               = 5'h01,
    OP_WATCHDOG_RESTART    = 5'h02,
    OP_BREAK               = 5'h03,
    OP_DIRECT_DATA_LOAD    = 5'h04,
    OP_DIRECT_DATA_WRITE   = 5'h05,
    OP_POINTER_WRITE       = 5'h06,
    OP_CODE_MEMORY_READ    = 5'h07,
    OP_CODE_MEMORY_WRITE   = 5'h08,
    OP_IO_READ             = 5'h09,
    OP_IO_WRITE            = 5'h0A,
    OP_PUSH                = 5'h0B,
    OP_POP                 = 5'h0C,
    OP_IO_BIT_SET          = 5'h0D,
    OP_IO_BIT_CLEAR        = 5'h0E,
    OP_LEFT_SHIFT_ZERO     = 5'h0F,
    OP_RIGHT_SHIFT_ZERO    = 5'h10,
    OP_ROTATE_LEFT_CARRY   = 5'h11,
    OP_ROTATE_RIGHT_CARRY  = 5'h12,
    OP_ARITH_RIGHT_SHIFT   = 5'h13,
    OP_NIBBLE_SWAP         = 5'h14,
    OP_FLAG_SET            = 5'h15,
    OP_FLAG_CLEAR          = 5'h16,
    OP_T_FLAG_CAPTURE      = 5'h17,
    OP_T_FLAG_TO_BIT       = 5'h18
  } msbfe_op_t;

  typedef enum logic {
    EX_IDLE = 1'b0,
    EX_RUN  = 1'b1
  } msbfe_state_t;

  typedef enum logic [1:0] {
    PM_PLAIN    = 2'h0,
    PM_POST_INC = 2'h1,
    PM_PRE_DEC  = 2'h2,
    PM_DISP     = 2'h3
  } msbfe_ptr_mode_t;
endpackage

// file: verif/mcu_store_bit_flag_exec_tb.sv
`include "msbfe_params.svh"
module mcu_store_bit_flag_exec_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import msbfe_pkg::*;
  logic        sys_clk = 0, rst_n = 0, go = 0, wr = 0;
  logic [7:0]  addr = 0, v, f;
  logic [31:0] wdata = 0, haddr, hwdata, hrdata, rdata;
  logic [1:0]  htrans;
  logic        hsel, hwrite, hreadyout, done;
  logic        sleepReq, watchdogRestart, debugBreak;
  logic [15:0] e;
  logic [31:0] expQ[$];
  int          mismatches = 0, checks_done = 0, pulses = 0;
  msbfe_op_t   sh[6] = '{OP_LEFT_SHIFT_ZERO, OP_RIGHT_SHIFT_ZERO,
    OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY, OP_ARITH_RIGHT_SHIFT,
    OP_NIBBLE_SWAP};
  always #12.5 sys_clk = ~sys_clk;
  msbfe_core msbfe_core_i (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(), .sleepReq(sleepReq),
    .watchdogRestart(watchdogRestart), .debugBreak(debugBreak));
  msbfe_host msbfe_host_i (.sys_clk(sys_clk), .go(go), .wr(wr), .addr(addr),
    .wdata(wdata), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
    .rdata(rdata), .done(done));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    if (rst_n) pulses <= pulses + sleepReq + watchdogRestart + debugBreak;
    if (done === 1'b1 && hwrite === 1'b0) chk(rdata, expQ.pop_front());
  end
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    {go, wr, addr, wdata} <= {1'b1, w, a, d};
    @(posedge sys_clk);
    go <= 1'b0;
    @(posedge sys_clk);
    while (done !== 1'b1) @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    expQ.push_back(x);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic setr(input logic [4:0] i, input logic [7:0] d);
    bus(1'b1, `MSBFE_OFF_REGIDX, {27'h0, i});
    bus(1'b1, `MSBFE_OFF_REGDATA, {24'h0, d});
  endtask
  task automatic getr(input logic [4:0] i, input logic [7:0] x);
    bus(1'b1, `MSBFE_OFF_REGIDX, {27'h0, i});
    rd(`MSBFE_OFF_REGDATA, {24'h0, x});
  endtask
  task automatic mem(input logic [7:0] a, input logic [7:0] x);
    bus(1'b1, `MSBFE_OFF_MEMADDR, {24'h0, a});
    rd(`MSBFE_OFF_MEMDATA, {24'h0, x});
  endtask
  task automatic cmd(input msbfe_op_t op, input logic [4:0] r,
    input logic [2:0] b, input logic [1:0] p, input logic [1:0] m,
    input logic [5:0] q);
    bus(1'b1, `MSBFE_OFF_CMD, {9'h0, q, m, p, b, r, op});
  endtask
  function automatic logic [15:0] shx(msbfe_op_t op, logic [7:0] x, fl);
    logic [7:0] r;
    logic       c;
    c = x[0];
    case (op)
      OP_LEFT_SHIFT_ZERO: {r, c} = {x[6:0], 1'b0, x[7]};
      OP_ROTATE_LEFT_CARRY: {r, c} = {x[6:0], fl[0], x[7]};
      OP_RIGHT_SHIFT_ZERO: r = {1'b0, x[7:1]};
      OP_ROTATE_RIGHT_CARRY: r = {fl[0], x[7:1]};
      OP_ARITH_RIGHT_SHIFT: r = {x[7], x[7:1]};
      default: return {x[3:0], x[7:4], fl};
    endcase
    return {r, fl[7:4], r[7] ^ c, r[7], r == 8'h00, c};
  endfunction
  initial begin
    #200000;
    mismatches++;
    results();
  end
  initial begin
    void'($urandom(64974));
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd(`MSBFE_OFF_FLAGS, 32'h0);
    rd(`MSBFE_OFF_SP, 32'hFF);
    $display("test reset done");
    foreach (sh[k]) for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 8'h80 : 8'($urandom);
      f = 8'($urandom);
      e = shx(sh[k], v, f);
      bus(1'b1, `MSBFE_OFF_FLAGS, {24'h0, f});
      setr(16, v);
      cmd(sh[k], 16, 0, 0, 0, 0);
      getr(16, e[15:8]);
      rd(`MSBFE_OFF_FLAGS, {24'h0, e[7:0]});
    end
    $display("test shifts done");
    for (int s = 0; s < 8; s++) begin
      v = 8'($urandom);
      bus(1'b1, `MSBFE_OFF_FLAGS, 32'h0);
      cmd(OP_FLAG_SET, 0, 3'(s), 0, 0, 0);
      rd(`MSBFE_OFF_FLAGS, 32'h1 << s);
      bus(1'b1, `MSBFE_OFF_FLAGS, 32'hFF);
      cmd(OP_FLAG_CLEAR, 0, 3'(s), 0, 0, 0);
      rd(`MSBFE_OFF_FLAGS, ~(32'h1 << s) & 32'hFF);
      bus(1'b1, `MSBFE_OFF_FLAGS, 32'h0);
      setr(5, v);
      setr(6, 8'h0);
      cmd(OP_T_FLAG_CAPTURE, 5, 3'(s), 0, 0, 0);
      rd(`MSBFE_OFF_FLAGS, {25'h0, v[s], 6'h0});
      cmd(OP_T_FLAG_TO_BIT, 6, 3'(s), 0, 0, 0);
      getr(6, 8'(v[s]) << s);
    end
    $display("test flags done");
    {v, f} = 16'($urandom);
    bus(1'b1, `MSBFE_OFF_FLAGS, {24'h0, f});
    setr(3, v); setr(26, 8'h10); setr(27, 0); setr(28, 8'h20);
    setr(29, 0); setr(30, 8'h30); setr(31, 0);
    cmd(OP_POINTER_WRITE, 3, 0, 0, 1, 0);
    cmd(OP_POINTER_WRITE, 3, 0, 1, 2, 0);
    cmd(OP_POINTER_WRITE, 3, 0, 2, 3, 5);
    bus(1'b1, `MSBFE_OFF_ADDR, 32'h40);
    cmd(OP_DIRECT_DATA_WRITE, 3, 0, 0, 0, 0);
    cmd(OP_DIRECT_DATA_LOAD, 4, 0, 0, 0, 0);
    cmd(OP_PUSH, 3, 0, 0, 0, 0);
    mem(8'h10, v);
    getr(26, 8'h11);
    mem(8'h1F, v);
    getr(28, 8'h1F);
    mem(8'h35, v);
    getr(30, 8'h30);
    mem(8'h40, v);
    getr(4, v);
    mem(8'hFF, v);
    rd(`MSBFE_OFF_SP, 32'hFE);
    cmd(OP_POP, 7, 0, 0, 0, 0);
    getr(7, v);
    rd(`MSBFE_OFF_SP, 32'hFF);
    $display("test stores done");
    bus(1'b1, `MSBFE_OFF_MEMADDR, 32'h5);
    cmd(OP_IO_WRITE, 3, 0, 0, 0, 5);
    cmd(OP_IO_BIT_SET, 0, 2, 0, 0, 5);
    cmd(OP_IO_BIT_CLEAR, 0, 7, 0, 0, 5);
    cmd(OP_IO_READ, 8, 0, 0, 0, 5);
    getr(8, (v | 8'h04) & 8'h7F);
    setr(0, v); setr(1, ~v); setr(30, 8'h06);
    cmd(OP_CODE_MEMORY_WRITE, 0, 0, 0, 0, 0);
    setr(30, 8'h07);
    cmd(OP_CODE_MEMORY_READ, 9, 0, 2, 2, 0);
    getr(9, ~v);
    getr(30, 8'h08);
    bus(1'b1, `MSBFE_OFF_MEMADDR, 32'h3);
    rd(`MSBFE_OFF_CODEDATA, {16'h0, ~v, v});
    $display("test io and code done");
    cmd(OP_NOP, 0, 0, 0, 0, 0);
    cmd(OP_SLEEP, 0, 0, 0, 0, 0);
    cmd(OP_WATCHDOG_RESTART, 0, 0, 0, 0, 0);
    cmd(OP_BREAK, 0, 0, 0, 0, 0);
    rd(`MSBFE_OFF_FLAGS, {24'h0, f});
    repeat (4) @(posedge sys_clk);
    chk(32'(pulses), 32'h3);
    $display("test control done");
    results();
  end
endmodule

// file: verif/msbfe_host.sv
module msbfe_host (
  input  wire logic        sys_clk,
  input  wire logic        go,
  input  wire logic        wr,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [31:0] hwdata,
  output logic      [31:0] rdata,
  output logic             done
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] phase = 2'h0;
  initial begin
    {hsel, haddr, htrans, hwrite, hwdata, rdata, done} = '0;
  end
  // Address held until ready, then data until ready again
  always @(posedge sys_clk) begin
    done <= 1'b0;
    case (phase)
      2'h0: begin
        hwdata <= ~hwdata;
        if (go) begin
          {hsel, htrans, hwrite} <= {1'b1, 2'h2, wr};
          haddr <= {24'h0, addr};
          phase <= 2'h1;
        end
      end
      2'h1: if (hready) begin
        {hsel, htrans} <= 3'h0;
        hwdata <= wdata;
        phase <= 2'h2;
      end
      default: if (hready) begin
        rdata <= hrdata;
        done <= 1'b1;
        phase <= 2'h0;
      end
    endcase
  end
endmodule
